//--- irq_src_pkg.sv
// Shared constants and types for the interrupt source and return logic.
package irq_src_pkg;

	// ==========================================================
	// Source indices, in polling order.
	localparam int         SRC_N    = 11;
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_TMR0 = 4'h1;
	localparam logic [3:0] SRC_EXT1 = 4'h2;
	localparam logic [3:0] SRC_TMR1 = 4'h3;
	localparam logic [3:0] SRC_SER  = 4'h4;
	localparam logic [3:0] SRC_TMR2 = 4'h5;
	localparam logic [3:0] SRC_EXT2 = 4'h6;
	localparam logic [3:0] SRC_WDT  = 4'ha;

	// ==========================================================
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] REG_TIMER_CTL  = 8'h88;
	localparam logic [7:0] REG_EXT_EDGE   = 8'h91;
	localparam logic [7:0] REG_SERIAL_CTL = 8'h98;
	localparam logic [7:0] REG_SRC_EN     = 8'ha8;
	localparam logic [7:0] REG_PRIO       = 8'hb8;
	localparam logic [7:0] REG_WAKEUP     = 8'hc6;
	localparam logic [7:0] REG_TIMER2_CTL = 8'hc8;
	localparam logic [7:0] REG_MISC_FLAG  = 8'hd8;
	localparam logic [7:0] REG_EXT_EN     = 8'he8;
	localparam logic [7:0] REG_EXT_PRIO   = 8'hf8;

	// ==========================================================
	// Field positions and fixed read values.
	localparam int         TC_TF1      = 7;
	localparam int         TC_TF0      = 5;
	localparam int         TC_IE1      = 3;
	localparam int         TC_IT1      = 2;
	localparam int         TC_IE0      = 1;
	localparam int         TC_IT0      = 0;
	localparam int         EF_LO       = 4;
	localparam logic [7:0] EF_FIXED    = 8'h08;
	localparam int         SC_TI       = 1;
	localparam int         SC_RI       = 0;
	localparam int         EN_GLOBAL   = 7;
	localparam int         T2_TF2      = 7;
	localparam int         MF_WDT      = 3;
	localparam logic [7:0] MF_FIXED    = 8'h40;
	localparam logic [7:0] EXT_FIXED   = 8'he0;
	localparam int         WU_EXT0     = 0;
	localparam int         WU_EXT1     = 1;
	localparam int         WU_WDT      = 2;

	// ==========================================================
	// Reset values and timing.
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam int         MC_CLKS     = 4;

	// Return-address sequencer; one bit changes per step along push and pop paths, two on the step back to idle.
	typedef enum logic [2:0]
	{
		SEQ_IDLE    = 3'b000,
		SEQ_PUSH_LO = 3'b001,
		SEQ_PUSH_HI = 3'b011,
		SEQ_POP_HI  = 3'b100,
		SEQ_POP_LO  = 3'b110
	} seq_state_t;

endpackage

//--- pin_sampler.sv
// Synchroniser and machine-cycle sampler for one interrupt pin.
`timescale 1ns/1ps
module pin_sampler
(
	// Clock and reset.
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	// Pin and sampling strobe.
	input  wire logic pin_in,
	input  wire logic sample_in,
	// Sampled level and edge pulses.
	output logic      level_out,
	output logic      rise_out,
	output logic      fall_out
);

	logic sync1_ff;
	logic sync2_ff;
	logic samp_ff;
	logic rise_ff;
	logic fall_ff;
	logic nxt_samp;
	logic nxt_rise;
	logic nxt_fall;

	// Edges are judged only between machine-cycle samples, so a glitch shorter than one machine cycle can be missed.
	always_comb
	begin
		nxt_samp = sample_in ? sync2_ff : samp_ff;
		nxt_rise = sample_in & sync2_ff & ~samp_ff;
		nxt_fall = sample_in & ~sync2_ff & samp_ff;
	end

	// Idle level is high so that reset does not fake a falling edge.
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			samp_ff  <= 1'b1;
			rise_ff  <= 1'b0;
			fall_ff  <= 1'b0;
		end
		else
		begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
			samp_ff  <= nxt_samp;
			rise_ff  <= nxt_rise;
			fall_ff  <= nxt_fall;
		end
	end

	assign level_out = samp_ff;
	assign rise_out  = rise_ff;
	assign fall_out  = fall_ff;

endmodule

//--- irq_source_logic.sv
// Interrupt sources, flags, arbitration and return sequencing for the core.
`timescale 1ns/1ps
module irq_source_logic
#(
	parameter int MC_CLKS = irq_src_pkg::MC_CLKS
)
(
	// Clock and reset.
	input  wire logic        CLK_IN,
	input  wire logic        RESET_N_IN,
	// Wishbone register slave.
	input  wire logic        WB_CYC_IN,
	input  wire logic        WB_STB_IN,
	input  wire logic        WB_WE_IN,
	input  wire logic [9:0]  WB_ADR_IN,
	input  wire logic [3:0]  WB_SEL_IN,
	input  wire logic [31:0] WB_DAT_IN,
	output logic      [31:0] WB_DAT_OUT,
	output logic             WB_ACK_OUT,
	// External request pins.
	input  wire logic [5:0]  EXT_REQ_PIN_IN,
	// On-chip event pulses.
	input  wire logic        TMR0_OVF_IN,
	input  wire logic        TMR1_OVF_IN,
	input  wire logic        TMR2_OVF_IN,
	input  wire logic        SERIAL_RX_DONE_IN,
	input  wire logic        SERIAL_TX_DONE_IN,
	input  wire logic        WDT_EVENT_IN,
	// Core handshake.
	input  wire logic        VECTOR_ACK_IN,
	input  wire logic        RETURN_FROM_HANDLER_INSTR_IN,
	input  wire logic [15:0] PC_IN,
	input  wire logic [7:0]  STACK_RDATA_IN,
	output logic             IRQ_REQ_OUT,
	output logic      [3:0]  IRQ_SRC_OUT,
	output logic             IRQ_HIGH_OUT,
	output logic             SERIAL_REQ_OUT,
	output logic             WAKE_OUT,
	output logic             STACK_PUSH_OUT,
	output logic             STACK_POP_OUT,
	output logic      [7:0]  STACK_WDATA_OUT,
	output logic      [15:0] RET_PC_OUT,
	output logic             RET_VALID_OUT
);

	// ==========================================================
	// Pin sampling.
	logic [5:0] lvl;
	logic [5:0] rise;
	logic [5:0] fall;
	logic [7:0] mc_cnt_ff;
	logic [7:0] nxt_mc_cnt;
	logic       mc_stb_ff;
	logic       nxt_mc_stb;

	// Machine-cycle strobe paces the pin samples.
	always_comb
	begin
		nxt_mc_stb = (mc_cnt_ff == 8'(MC_CLKS - 1));
		nxt_mc_cnt = nxt_mc_stb ? 8'h00 : mc_cnt_ff + 8'h01;
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			mc_cnt_ff <= 8'h00;
			mc_stb_ff <= 1'b0;
		end
		else
		begin
			mc_cnt_ff <= nxt_mc_cnt;
			mc_stb_ff <= nxt_mc_stb;
		end
	end

	// Six external pins, one sampler each; edge sources rely on each level lasting a machine cycle.
	for (genvar g = 0; g < 6; g++)
	begin : g_pin
		pin_sampler u_samp
		(
			.clk_in     (CLK_IN),
			.reset_n_in (RESET_N_IN),
			.pin_in     (EXT_REQ_PIN_IN[g]),
			.sample_in  (mc_stb_ff),
			.level_out  (lvl[g]),
			.rise_out   (rise[g]),
			.fall_out   (fall[g])
		);
	end

	// ==========================================================
	// Register state.
	logic       it0_ff, it1_ff, ie0_ff, ie1_ff;
	logic       tf0_ff, tf1_ff, tf2_ff, ri_ff, ti_ff, wdtf_ff;
	logic [3:0] ef_ff;
	logic [7:0] en_ff, prio_ff;
	logic [4:0] xen_ff, xprio_ff;
	logic [2:0] wake_mask_ff;
	logic       ins_hi_ff, ins_lo_ff;
	logic       nxt_it0, nxt_it1, nxt_ie0, nxt_ie1;
	logic       nxt_tf0, nxt_tf1, nxt_tf2, nxt_ri, nxt_ti, nxt_wdtf;
	logic [3:0] nxt_ef;
	logic [7:0] nxt_en, nxt_prio;
	logic [4:0] nxt_xen, nxt_xprio;
	logic [2:0] nxt_wake_mask;
	logic       nxt_ins_hi, nxt_ins_lo;

	logic       ack_ff, nxt_ack;
	logic [7:0] rdat_ff, nxt_rdat;
	logic [7:0] idx;
	logic [7:0] wd;
	logic       wr;
	logic       vec;
	logic       ret_done;

	// Sources and arbitration terms.
	localparam int SRC_N_W = irq_src_pkg::SRC_N;
	logic [SRC_N_W-1:0] pend, srcen, srcpri, elig;
	logic       req_ff, hi_ff, nxt_req, nxt_hi;
	logic [3:0] src_ff, nxt_src;
	logic       ser_ff, nxt_ser, wake_ff, nxt_wake;

	assign idx = WB_ADR_IN[9:2];
	assign wd  = WB_DAT_IN[7:0];
	// A write lands on the edge where the master sees ack.
	assign wr  = WB_CYC_IN & WB_STB_IN & WB_WE_IN & WB_SEL_IN[0] & ack_ff;
	// Acknowledge refers to the source shown on the request outputs.
	assign vec = VECTOR_ACK_IN & req_ff;

	// Level mode reports the pin itself, edge mode the latched event.
	always_comb
	begin
		pend[0]    = it0_ff ? ie0_ff : ~lvl[0];
		pend[1]    = tf0_ff;
		pend[2]    = it1_ff ? ie1_ff : ~lvl[1];
		pend[3]    = tf1_ff;
		pend[4]    = ri_ff | ti_ff;
		pend[5]    = tf2_ff;
		pend[9:6]  = ef_ff;
		pend[10]   = wdtf_ff;
		srcen      = {xen_ff, en_ff[5:0]};
		srcpri     = {xprio_ff, prio_ff[5:0]};
		elig       = pend & srcen & {SRC_N_W{en_ff[irq_src_pkg::EN_GLOBAL]}};
	end

	// Highest priority first, then polling order; blocked levels are held off.
	always_comb
	begin
		nxt_req = 1'b0;
		nxt_hi  = 1'b0;
		nxt_src = 4'h0;
		for (int i = SRC_N_W - 1; i >= 0; i--)
		begin
			if (elig[i] && !srcpri[i] && !ins_hi_ff && !ins_lo_ff)
			begin
				nxt_req = 1'b1;
				nxt_src = 4'(i);
			end
		end
		for (int i = SRC_N_W - 1; i >= 0; i--)
		begin
			if (elig[i] && srcpri[i] && !ins_hi_ff)
			begin
				nxt_req = 1'b1;
				nxt_hi  = 1'b1;
				nxt_src = 4'(i);
			end
		end
		// Hold off a new request while the previous one is being taken.
		if (vec)
		begin
			nxt_req = 1'b0;
		end
		nxt_ser  = ri_ff | ti_ff;
		nxt_wake = (wake_mask_ff[irq_src_pkg::WU_EXT0] & pend[0])
			| (wake_mask_ff[irq_src_pkg::WU_EXT1] & pend[2])
			| (wake_mask_ff[irq_src_pkg::WU_WDT] & wdtf_ff);
	end

	// Flag and control updates; a hardware set always beats a clear in the same cycle.
	always_comb
	begin
		nxt_it0 = it0_ff;
		nxt_it1 = it1_ff;
		nxt_ie0 = ie0_ff;
		nxt_ie1 = ie1_ff;
		nxt_tf0 = tf0_ff;
		nxt_tf1 = tf1_ff;
		nxt_tf2 = tf2_ff;
		nxt_ri = ri_ff;
		nxt_ti = ti_ff;
		nxt_wdtf = wdtf_ff;
		nxt_ef = ef_ff;
		nxt_en = en_ff;
		nxt_prio = prio_ff;
		nxt_xen = xen_ff;
		nxt_xprio = xprio_ff;
		nxt_wake_mask = wake_mask_ff;
		nxt_ins_hi = ins_hi_ff;
		nxt_ins_lo = ins_lo_ff;
		// Vectoring clears timer 0/1 and external flags, never timer 2 or serial.
		if (vec)
		begin
			if (src_ff == irq_src_pkg::SRC_EXT0) nxt_ie0 = 1'b0;
			if (src_ff == irq_src_pkg::SRC_EXT1) nxt_ie1 = 1'b0;
			if (src_ff == irq_src_pkg::SRC_TMR0) nxt_tf0 = 1'b0;
			if (src_ff == irq_src_pkg::SRC_TMR1) nxt_tf1 = 1'b0;
			for (int k = 0; k < 4; k++)
			begin
				if (src_ff == irq_src_pkg::SRC_EXT2 + 4'(k)) nxt_ef[k] = 1'b0;
			end
			if (hi_ff) nxt_ins_hi = 1'b1;
			else nxt_ins_lo = 1'b1;
		end
		// Return drops the most recent level only, restoring the prior state.
		if (ret_done)
		begin
			if (ins_hi_ff) nxt_ins_hi = 1'b0;
			else nxt_ins_lo = 1'b0;
		end
		if (wr)
		begin
			unique case (idx)
				irq_src_pkg::REG_TIMER_CTL:
				begin
					nxt_tf1 = wd[irq_src_pkg::TC_TF1];
					nxt_tf0 = wd[irq_src_pkg::TC_TF0];
					nxt_ie1 = wd[irq_src_pkg::TC_IE1];
					nxt_it1 = wd[irq_src_pkg::TC_IT1];
					nxt_ie0 = wd[irq_src_pkg::TC_IE0];
					nxt_it0 = wd[irq_src_pkg::TC_IT0];
				end
				irq_src_pkg::REG_EXT_EDGE:   nxt_ef = wd[7:irq_src_pkg::EF_LO];
				irq_src_pkg::REG_SERIAL_CTL:
				begin
					nxt_ti = wd[irq_src_pkg::SC_TI];
					nxt_ri = wd[irq_src_pkg::SC_RI];
				end
				irq_src_pkg::REG_SRC_EN:     nxt_en = wd;
				irq_src_pkg::REG_PRIO:       nxt_prio = wd;
				irq_src_pkg::REG_WAKEUP:     nxt_wake_mask = wd[2:0];
				irq_src_pkg::REG_TIMER2_CTL: nxt_tf2 = wd[irq_src_pkg::T2_TF2];
				irq_src_pkg::REG_MISC_FLAG:  nxt_wdtf = wd[irq_src_pkg::MF_WDT];
				irq_src_pkg::REG_EXT_EN:     nxt_xen = wd[4:0];
				irq_src_pkg::REG_EXT_PRIO:   nxt_xprio = wd[4:0];
				default:
				begin
					nxt_en = en_ff;
				end
			endcase
		end
		// Level mode keeps no latched event at all.
		if (!nxt_it0) nxt_ie0 = 1'b0;
		if (!nxt_it1) nxt_ie1 = 1'b0;
		// Hardware events, applied last so that they win.
		if (it0_ff && fall[0]) nxt_ie0 = 1'b1;
		if (it1_ff && fall[1]) nxt_ie1 = 1'b1;
		if (TMR0_OVF_IN) nxt_tf0 = 1'b1;
		if (TMR1_OVF_IN) nxt_tf1 = 1'b1;
		if (TMR2_OVF_IN) nxt_tf2 = 1'b1;
		if (SERIAL_RX_DONE_IN) nxt_ri = 1'b1;
		if (SERIAL_TX_DONE_IN) nxt_ti = 1'b1;
		if (WDT_EVENT_IN) nxt_wdtf = 1'b1;
		if (rise[2]) nxt_ef[0] = 1'b1;
		if (fall[3]) nxt_ef[1] = 1'b1;
		if (rise[4]) nxt_ef[2] = 1'b1;
		if (fall[5]) nxt_ef[3] = 1'b1;
	end

	// ==========================================================
	// Wishbone slave: ack one cycle after the strobe, unmapped reads return zero.
	always_comb
	begin
		nxt_ack  = WB_CYC_IN & WB_STB_IN & ~ack_ff;
		nxt_rdat = 8'h00;
		unique case (idx)
			irq_src_pkg::REG_TIMER_CTL:
			begin
				nxt_rdat[irq_src_pkg::TC_TF1] = tf1_ff;
				nxt_rdat[irq_src_pkg::TC_TF0] = tf0_ff;
				nxt_rdat[irq_src_pkg::TC_IE1] = pend[2];
				nxt_rdat[irq_src_pkg::TC_IT1] = it1_ff;
				nxt_rdat[irq_src_pkg::TC_IE0] = pend[0];
				nxt_rdat[irq_src_pkg::TC_IT0] = it0_ff;
			end
			irq_src_pkg::REG_EXT_EDGE:   nxt_rdat = {ef_ff, 4'h0} | irq_src_pkg::EF_FIXED;
			irq_src_pkg::REG_SERIAL_CTL: nxt_rdat = {6'h00, ti_ff, ri_ff};
			irq_src_pkg::REG_SRC_EN:     nxt_rdat = en_ff;
			irq_src_pkg::REG_PRIO:       nxt_rdat = prio_ff;
			irq_src_pkg::REG_WAKEUP:     nxt_rdat = {5'h00, wake_mask_ff};
			irq_src_pkg::REG_TIMER2_CTL: nxt_rdat = {tf2_ff, 7'h00};
			irq_src_pkg::REG_MISC_FLAG:  nxt_rdat = {4'h0, wdtf_ff, 3'h0} | irq_src_pkg::MF_FIXED;
			irq_src_pkg::REG_EXT_EN:     nxt_rdat = {3'h0, xen_ff} | irq_src_pkg::EXT_FIXED;
			irq_src_pkg::REG_EXT_PRIO:   nxt_rdat = {3'h0, xprio_ff} | irq_src_pkg::EXT_FIXED;
			default:                     nxt_rdat = 8'h00;
		endcase
	end

	// ==========================================================
	// Return-address sequencer.
	irq_src_pkg::seq_state_t seq_ff, nxt_seq;
	logic        push_ff, pop_ff, nxt_push, nxt_pop;
	logic [7:0]  wdata_ff, nxt_wdata;
	logic [15:0] pc_ff, nxt_pc;
	logic [15:0] rpc_ff, nxt_rpc;
	logic        rvalid_ff, nxt_rvalid;

	assign ret_done = (seq_ff == irq_src_pkg::SEQ_POP_LO);

	// Push goes low byte then high; pop takes high byte then low.
	always_comb
	begin
		nxt_seq    = seq_ff;
		nxt_pc     = pc_ff;
		nxt_rpc    = rpc_ff;
		nxt_rvalid = 1'b0;
		unique case (seq_ff)
			irq_src_pkg::SEQ_IDLE:
			begin
				if (vec)
				begin
					nxt_seq = irq_src_pkg::SEQ_PUSH_LO;
					nxt_pc  = PC_IN;
				end
				else if (RETURN_FROM_HANDLER_INSTR_IN)
				begin
					nxt_seq = irq_src_pkg::SEQ_POP_HI;
				end
			end
			irq_src_pkg::SEQ_PUSH_LO: nxt_seq = irq_src_pkg::SEQ_PUSH_HI;
			irq_src_pkg::SEQ_PUSH_HI: nxt_seq = irq_src_pkg::SEQ_IDLE;
			irq_src_pkg::SEQ_POP_HI:
			begin
				nxt_rpc[15:8] = STACK_RDATA_IN;
				nxt_seq       = irq_src_pkg::SEQ_POP_LO;
			end
			irq_src_pkg::SEQ_POP_LO:
			begin
				nxt_rpc[7:0] = STACK_RDATA_IN;
				nxt_rvalid   = 1'b1;
				nxt_seq      = irq_src_pkg::SEQ_IDLE;
			end
			default: nxt_seq = irq_src_pkg::SEQ_IDLE;
		endcase
		nxt_push  = (nxt_seq == irq_src_pkg::SEQ_PUSH_LO) || (nxt_seq == irq_src_pkg::SEQ_PUSH_HI);
		nxt_pop   = (nxt_seq == irq_src_pkg::SEQ_POP_HI) || (nxt_seq == irq_src_pkg::SEQ_POP_LO);
		nxt_wdata = (nxt_seq == irq_src_pkg::SEQ_PUSH_HI) ? nxt_pc[15:8] : nxt_pc[7:0];
	end

	// ==========================================================
	// All state registers but the machine-cycle counter and strobe; reset leaves every source disabled and idle.
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			{it0_ff, it1_ff, ie0_ff, ie1_ff} <= 4'h0;
			{tf0_ff, tf1_ff, tf2_ff}         <= 3'h0;
			{ri_ff, ti_ff, wdtf_ff}          <= 3'h0;
			ef_ff        <= 4'h0;
			en_ff        <= irq_src_pkg::RST_BYTE;
			prio_ff      <= irq_src_pkg::RST_BYTE;
			xen_ff       <= 5'h00;
			xprio_ff     <= 5'h00;
			wake_mask_ff <= 3'h0;
			ins_hi_ff    <= 1'b0;
			ins_lo_ff    <= 1'b0;
			ack_ff       <= 1'b0;
			rdat_ff      <= 8'h00;
			req_ff       <= 1'b0;
			hi_ff        <= 1'b0;
			src_ff       <= 4'h0;
			ser_ff       <= 1'b0;
			wake_ff      <= 1'b0;
			seq_ff       <= irq_src_pkg::SEQ_IDLE;
			push_ff      <= 1'b0;
			pop_ff       <= 1'b0;
			wdata_ff     <= 8'h00;
			pc_ff        <= 16'h0000;
			rpc_ff       <= 16'h0000;
			rvalid_ff    <= 1'b0;
		end
		else
		begin
			{it0_ff, it1_ff, ie0_ff, ie1_ff} <= {nxt_it0, nxt_it1, nxt_ie0, nxt_ie1};
			{tf0_ff, tf1_ff, tf2_ff}         <= {nxt_tf0, nxt_tf1, nxt_tf2};
			{ri_ff, ti_ff, wdtf_ff}          <= {nxt_ri, nxt_ti, nxt_wdtf};
			ef_ff        <= nxt_ef;
			en_ff        <= nxt_en;
			prio_ff      <= nxt_prio;
			xen_ff       <= nxt_xen;
			xprio_ff     <= nxt_xprio;
			wake_mask_ff <= nxt_wake_mask;
			ins_hi_ff    <= nxt_ins_hi;
			ins_lo_ff    <= nxt_ins_lo;
			ack_ff       <= nxt_ack;
			rdat_ff      <= nxt_rdat;
			req_ff       <= nxt_req;
			hi_ff        <= nxt_hi;
			src_ff       <= nxt_src;
			ser_ff       <= nxt_ser;
			wake_ff      <= nxt_wake;
			seq_ff       <= nxt_seq;
			push_ff      <= nxt_push;
			pop_ff       <= nxt_pop;
			wdata_ff     <= nxt_wdata;
			pc_ff        <= nxt_pc;
			rpc_ff       <= nxt_rpc;
			rvalid_ff    <= nxt_rvalid;
		end
	end

	// Outputs come straight from flip-flops.
	assign WB_ACK_OUT      = ack_ff;
	assign WB_DAT_OUT      = {24'h000000, rdat_ff};
	assign IRQ_REQ_OUT     = req_ff;
	assign IRQ_SRC_OUT     = src_ff;
	assign IRQ_HIGH_OUT    = hi_ff;
	assign SERIAL_REQ_OUT  = ser_ff;
	assign WAKE_OUT        = wake_ff;
	assign STACK_PUSH_OUT  = push_ff;
	assign STACK_POP_OUT   = pop_ff;
	assign STACK_WDATA_OUT = wdata_ff;
	assign RET_PC_OUT      = rpc_ff;
	assign RET_VALID_OUT   = rvalid_ff;

endmodule

//--- core_stack_model.sv
// Stack memory of the processor core that faces the return-address sequencer.
`timescale 1ns/1ps
module core_stack_model
(
	// Clock.
	input  wire logic       clk_in,
	// Stack port of the block.
	input  wire logic       push_in,
	input  wire logic       pop_in,
	input  wire logic [7:0] wdata_in,
	output logic      [7:0] rdata_out
);
	// =====
	// Byte stack
	logic [7:0] mem [0:255];
	logic [7:0] sp   = 8'h00;
	logic [7:0] last = 8'h00;
	// Bytes pile up in arrival order and a pop reads the newest one.
	always @(posedge clk_in)
	begin
		if (push_in)
			mem[sp] <= wdata_in;
		if (push_in)
			sp <= sp + 8'h01;
		if (pop_in)
			sp <= sp - 8'h01;
		if (pop_in)
			last <= rdata_out;
	end
	// Outside a pop the bus shows the inverse of its last byte, so a late read never finds stale data.
	assign rdata_out = pop_in ? mem[sp - 8'h01] : ~last;
endmodule

//--- irq_chk.sv
// Port checker for the interrupt source and return logic.
`timescale 1ns/1ps
module irq_chk
(
	// Watched ports.
	input wire logic        CLK_IN,
	input wire logic        RESET_N_IN,
	input wire logic        WB_CYC_IN,
	input wire logic        WB_STB_IN,
	input wire logic        WB_WE_IN,
	input wire logic [9:0]  WB_ADR_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic        WB_ACK_OUT,
	input wire logic        SERIAL_RX_DONE_IN,
	input wire logic        VECTOR_ACK_IN,
	input wire logic        RETURN_FROM_HANDLER_INSTR_IN,
	input wire logic [15:0] PC_IN,
	input wire logic [7:0]  STACK_RDATA_IN,
	input wire logic        IRQ_REQ_OUT,
	input wire logic        SERIAL_REQ_OUT,
	input wire logic        STACK_PUSH_OUT,
	input wire logic        STACK_POP_OUT,
	input wire logic [7:0]  STACK_WDATA_OUT,
	input wire logic [15:0] RET_PC_OUT,
	input wire logic        RET_VALID_OUT
);
	// =====
	// Properties
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);
	// The sequencer counts as idle only with both stack strobes low.
	wire logic       idle  = !STACK_PUSH_OUT && !STACK_POP_OUT;
	wire logic [7:0] pc_lo = PC_IN[7:0];
	wire logic [7:0] pc_hi = PC_IN[15:8];
	property p_ack_next;
		WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("bus request not answered");
	property p_ack_once;
		WB_ACK_OUT |=> !WB_ACK_OUT;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	property p_edge_read;
		WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN[9:2] == irq_src_pkg::REG_EXT_EDGE |-> WB_DAT_OUT[3:0] == 4'h8;
	endproperty
	a_edge_read: assert property (p_edge_read) else $error("edge flag low bits wrong");
	property p_ser_set;
		$rose(SERIAL_RX_DONE_IN) |-> ##[1:2] SERIAL_REQ_OUT;
	endproperty
	a_ser_set: assert property (p_ser_set) else $error("serial request missing");
	// Only a bus write may clear the serial flags, vectoring must not.
	property p_ser_hold;
		SERIAL_REQ_OUT && !WB_CYC_IN && !$past(WB_CYC_IN) |=> SERIAL_REQ_OUT;
	endproperty
	a_ser_hold: assert property (p_ser_hold) else $error("serial request dropped");
	property p_vec_drop;
		VECTOR_ACK_IN && IRQ_REQ_OUT |=> !IRQ_REQ_OUT;
	endproperty
	a_vec_drop: assert property (p_vec_drop) else $error("request stays after vector");
	property p_vec_push;
		VECTOR_ACK_IN && IRQ_REQ_OUT && idle |=> STACK_PUSH_OUT && STACK_WDATA_OUT == $past(pc_lo)
			##1 STACK_PUSH_OUT && STACK_WDATA_OUT == $past(pc_hi, 2) ##1 !STACK_PUSH_OUT;
	endproperty
	a_vec_push: assert property (p_vec_push) else $error("push order wrong");
	property p_ret_pop;
		RETURN_FROM_HANDLER_INSTR_IN && idle |=> STACK_POP_OUT ##1 STACK_POP_OUT ##1 RET_VALID_OUT
			&& RET_PC_OUT == {$past(STACK_RDATA_IN, 2), $past(STACK_RDATA_IN)};
	endproperty
	a_ret_pop: assert property (p_ret_pop) else $error("return pop wrong");
	c_ret: cover property (RET_VALID_OUT);
	c_ser_vec: cover property (SERIAL_REQ_OUT && VECTOR_ACK_IN);
	c_write: cover property (WB_ACK_OUT && WB_WE_IN);
endmodule
bind irq_source_logic irq_chk chk_i
(
	.CLK_IN, .RESET_N_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_DAT_OUT, .WB_ACK_OUT,
	.SERIAL_RX_DONE_IN, .VECTOR_ACK_IN, .RETURN_FROM_HANDLER_INSTR_IN, .PC_IN, .STACK_RDATA_IN,
	.IRQ_REQ_OUT, .SERIAL_REQ_OUT, .STACK_PUSH_OUT, .STACK_POP_OUT, .STACK_WDATA_OUT, .RET_PC_OUT, .RET_VALID_OUT
);

//--- interrupt_source_and_return_logic_bench.sv
// Self-checking bench for the interrupt source and return logic.
`timescale 1ns/1ps
`define CHK(g, e) chk((g), (e))
module interrupt_source_and_return_logic_bench;
	// =====
	// Signals, model state and tasks
	typedef struct { int e; logic [7:0] en, r, f, fv; logic [3:0] s; } src_t;
	logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, vack = 1'b0, ret_i = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [31:0] dat = 32'h0, rdo, seed = 32'h6f33deb0, v;
	logic [5:0]  pin = 6'b101011, ev = 6'h00;
	logic [15:0] pc = 16'h0000, rpc;
	logic [15:0] pcs[$];
	logic        ack, irq, hi, ser, wake, push, pop, rv;
	logic [3:0]  src;
	logic [7:0]  wd, sd;
	int          n_fail = 0, cmp_count = 0, cycles = 0, k;
	src_t        tab[5] = '{'{0, 8'h82, 8'h88, 8'h20, 8'h00, 4'h1}, '{1, 8'h88, 8'h88, 8'h80, 8'h00, 4'h3},
		'{2, 8'ha0, 8'hc8, 8'h80, 8'h80, 4'h5}, '{3, 8'h90, 8'h98, 8'h01, 8'h01, 4'h4},
		'{4, 8'h90, 8'h98, 8'h02, 8'h02, 4'h4}};
	irq_source_logic #(.MC_CLKS(2)) DUT
	(
		.CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_WE_IN(we), .WB_ADR_IN(adr),
		.WB_SEL_IN(4'hf), .WB_DAT_IN(dat), .WB_DAT_OUT(rdo), .WB_ACK_OUT(ack), .EXT_REQ_PIN_IN(pin),
		.TMR0_OVF_IN(ev[0]), .TMR1_OVF_IN(ev[1]), .TMR2_OVF_IN(ev[2]), .SERIAL_RX_DONE_IN(ev[3]),
		.SERIAL_TX_DONE_IN(ev[4]), .WDT_EVENT_IN(ev[5]), .VECTOR_ACK_IN(vack), .RETURN_FROM_HANDLER_INSTR_IN(ret_i),
		.PC_IN(pc), .STACK_RDATA_IN(sd), .IRQ_REQ_OUT(irq), .IRQ_SRC_OUT(src), .IRQ_HIGH_OUT(hi), .SERIAL_REQ_OUT(ser),
		.WAKE_OUT(wake), .STACK_PUSH_OUT(push), .STACK_POP_OUT(pop), .STACK_WDATA_OUT(wd), .RET_PC_OUT(rpc),
		.RET_VALID_OUT(rv)
	);
	core_stack_model CORE (.clk_in(clk), .push_in(push), .pop_in(pop), .wdata_in(wd), .rdata_out(sd));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask
	// One classic cycle; the request stays put until ack is seen at an edge.
	task automatic wb(input logic [7:0] i, input logic w, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= {24'h0, d};
		@(posedge clk);
		while (!ack)
			@(posedge clk);
		q = rdo[7:0];
		cyc <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] q;
		wb(i, 1'b1, d, q);
	endtask
	task automatic rchk(input logic [7:0] i, input logic [7:0] e);
		logic [7:0] q;
		wb(i, 1'b0, 8'h00, q);
		`CHK(q, e);
	endtask
	task automatic pulse(input int e);
		ev <= 6'h01 << e;
		@(posedge clk);
		ev <= 6'h00;
	endtask
	// The core acks after a random delay, so both prompt and slow answers occur.
	task automatic take(input logic [3:0] s);
		logic [31:0] r;
		while (!irq)
			@(posedge clk);
		`CHK(src, s);
		r = rnd();
		repeat (r[1:0]) @(posedge clk);
		pc <= r[31:16];
		vack <= 1'b1;
		pcs.push_back(r[31:16]);
		@(posedge clk);
		vack <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic ret();
		ret_i <= 1'b1;
		@(posedge clk);
		ret_i <= 1'b0;
		while (!rv)
			@(posedge clk);
		`CHK(rpc, pcs.pop_back());
	endtask
	// Clock, and a ceiling on the run so a hang still ends in the report.
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_fail++;
			stop_test();
		end
	end
	// Main sequence.
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rchk(8'h91, 8'h08);
		rchk(8'h00, 8'h00);
		v = rnd();
		wr(8'h91, v[7:0]);
		rchk(8'h91, {v[7:4], 4'h8});
		wr(8'h91, 8'h00);
		for (k = 2; k < 6; k++)
		begin
			pin <= pin ^ (6'h01 << k);
			repeat (6) @(posedge clk);
			rchk(8'h91, 8'h08 | (8'h01 << (k + 2)));
			wr(8'h91, 8'h00);
			pin <= pin ^ (6'h01 << k);
			repeat (6) @(posedge clk);
			rchk(8'h91, 8'h08);
		end
		foreach (tab[i])
			repeat (2)
			begin
				pulse(tab[i].e);
				rchk(tab[i].r, tab[i].f);
				`CHK(ser, tab[i].s == 4'h4);
				wr(8'ha8, tab[i].en);
				take(tab[i].s);
				rchk(tab[i].r, tab[i].fv);
				wr(8'ha8, 8'h00);
				wr(tab[i].r, 8'h00);
				ret();
				`CHK(ser, 1'b0);
			end
		// A high-priority timer 1 preempts a low timer 0 handler; each return drops only the newest level.
		wr(8'hb8, 8'h08);
		wr(8'ha8, 8'h8a);
		pulse(0);
		take(4'h1);
		pulse(0);
		repeat (4) @(posedge clk);
		`CHK(irq, 1'b0);
		pulse(1);
		repeat (4) @(posedge clk);
		`CHK(hi, 1'b1);
		take(4'h3);
		ret();
		repeat (4) @(posedge clk);
		`CHK(irq, 1'b0);
		ret();
		take(4'h1);
		ret();
		wr(8'ha8, 8'h00);
		wr(8'ha8, 8'h81);
		for (k = 0; k < 2; k++)
		begin
			wr(8'h88, 8'(k));
			pin <= pin ^ 6'h01;
			take(4'h0);
			rchk(8'h88, k ? 8'h01 : 8'h02);
			`CHK(wake, 1'b0);
			wr(8'hc6, 8'h01);
			repeat (2) @(posedge clk);
			`CHK(wake, k == 0);
			wr(8'hc6, 8'h00);
			pin <= pin ^ 6'h01;
			ret();
			repeat (8) @(posedge clk);
			`CHK(irq, 1'b0);
		end
		pulse(5);
		rchk(8'hd8, 8'h48);
		wr(8'hc6, 8'h04);
		repeat (2) @(posedge clk);
		`CHK(wake, 1'b1);
		stop_test();
	end
endmodule
